// ### spus_sequencer.sv
// supply power-up sequencer with axi4-lite register slave
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// - hold init 6 ms after supply detect
// - then enable boost at 3.8 V code
// - wait boost power-good before advancing
// - sample strap 2 ms, load host/boost settings
// - strap maps to four supply/boost pairs
// - boost good again, enable host regulator
// - active only after host supply good
// - same sequence with or without boost
// - software selects four host supply codes
// - disable bit turns host regulator off
// - host good deglitched over 125 us
// - still bad 10 ms after change: error
// - error with response enabled: fault state
// - core regulator enabled except during reset
// - status and interrupt registers notify host
module spus_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spus_pkg::spus_analog_t analog_in,
  input wire logic [1:0] supply_select_strap,
  input wire logic ext_alert,
  output spus_pkg::spus_reg_ctl_t reg_ctl,
  output logic irq
);
  // synchronised analog levels, two flops each
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic supply_ok;
  logic boost_good;
  logic host_good_raw;
  logic [1:0] strap_s;
  // sequencer state and timer
  spus_pkg::spus_state_t state_reg;
  logic [31:0] timer_reg;
  // deglitch filter
  logic host_good_filt_reg;
  logic [31:0] glitch_cnt_reg;
  // supervision timer after change or enable
  logic [31:0] sup_cnt_reg;
  logic sup_run_reg;
  logic host_err_reg;
  // software control register
  logic [1:0] vset_reg;
  logic reg_off_reg;
  logic fault_off_reg;
  // interrupt status and mask
  logic [spus_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [spus_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [spus_pkg::IRQ_W-1:0] irq_event;
  logic active_prev_reg;
  logic alert_prev_reg;
  // axi holding registers
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic vset_write;
  logic host_en;
  logic [3:0] strap_pair; // decoded host/boost codes
  logic alert_m_reg; // alert synchroniser first flop
  logic ext_alert_s; // alert synchroniser second flop

  // strap decode to host/boost pair, shared by several spots
  function automatic logic [3:0] strap_decode(input logic [1:0] s);
    case (s)
      spus_pkg::STRAP_RES_GND: strap_decode = {spus_pkg::VSET_1V5, spus_pkg::BOOST_2V7};
      spus_pkg::STRAP_SHORT_GND: strap_decode = {spus_pkg::VSET_1V8, spus_pkg::BOOST_2V7};
      spus_pkg::STRAP_SHORT_CORE: strap_decode = {spus_pkg::VSET_2V5, spus_pkg::BOOST_3V8};
      default: strap_decode = {spus_pkg::VSET_3V3, spus_pkg::BOOST_4V7};
    endcase
  endfunction

  // two-flop synchronisers for pins from the analog side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {analog_in.supply_above_detect, analog_in.boost_good, analog_in.host_supply_good,
                    supply_select_strap};
      sync2_reg <= sync1_reg;
    end
  end
  assign supply_ok = sync2_reg[4];
  assign boost_good = sync2_reg[3];
  assign host_good_raw = sync2_reg[2];
  assign strap_s = sync2_reg[1:0];
  assign strap_pair = strap_decode(strap_s);

  // power-up state machine; timer counts down per timed state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= spus_pkg::ST_OFF;
      timer_reg <= 32'h0000_0000;
    end else if (!supply_ok) begin
      state_reg <= spus_pkg::ST_OFF;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        spus_pkg::ST_OFF: begin
          state_reg <= spus_pkg::ST_INIT;
          timer_reg <= 32'(spus_pkg::INIT_CYCLES - 1);
        end
        spus_pkg::ST_INIT: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg <= spus_pkg::ST_BOOST_WAIT;
          end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end
        end
        spus_pkg::ST_BOOST_WAIT: begin
          // boost fitted or not, only the good level matters
          if (boost_good) begin
            state_reg <= spus_pkg::ST_STRAP;
            timer_reg <= 32'(spus_pkg::STRAP_CYCLES - 1);
          end
        end
        spus_pkg::ST_STRAP: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg <= spus_pkg::ST_BOOST_RESET_WAIT;
            timer_reg <= 32'(spus_pkg::BOOST_SETTLE_CYCLES - 1);
          end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end
        end
        spus_pkg::ST_BOOST_RESET_WAIT: begin
          // good still shows the old code's level for a few cycles
          if (timer_reg != 32'h0000_0000) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else if (boost_good) begin
            state_reg <= spus_pkg::ST_HOST_WAIT;
          end
        end
        spus_pkg::ST_HOST_WAIT: begin
          if (host_good_filt_reg) begin
            state_reg <= spus_pkg::ST_ACTIVE;
          end else if (host_err_reg && !fault_off_reg) begin
            state_reg <= spus_pkg::ST_FAULT;
          end
        end
        spus_pkg::ST_ACTIVE: begin
          if (host_err_reg && !fault_off_reg) begin
            state_reg <= spus_pkg::ST_FAULT;
          end
        end
        spus_pkg::ST_FAULT: begin
          // back to host wait only once the error is cleared or response disabled
          if (!host_err_reg || fault_off_reg) begin
            state_reg <= spus_pkg::ST_HOST_WAIT;
          end
        end
        default: state_reg <= spus_pkg::ST_OFF;
      endcase
    end
  end

  // host regulator on from host-wait onward unless switched off
  assign host_en = (state_reg == spus_pkg::ST_HOST_WAIT || state_reg == spus_pkg::ST_ACTIVE ||
                    state_reg == spus_pkg::ST_FAULT) && !reg_off_reg;

  // regulator control outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_ctl <= '0;
    end else begin
      reg_ctl.core_supply_enable <= 1'b1;
      reg_ctl.host_supply_enable <= host_en;
      reg_ctl.host_supply_voltage_setting <= vset_reg;
      reg_ctl.boost_enable <= (state_reg != spus_pkg::ST_OFF) && (state_reg != spus_pkg::ST_INIT);
      if (state_reg == spus_pkg::ST_OFF || state_reg == spus_pkg::ST_INIT) begin
        reg_ctl.boost_voltage <= spus_pkg::BOOST_3V8;
      end else if (state_reg == spus_pkg::ST_STRAP && timer_reg == 32'h0000_0000) begin
        reg_ctl.boost_voltage <= strap_pair[1:0];
      end
    end
  end

  // deglitch: filtered level follows raw only after steady 125 us
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_good_filt_reg <= 1'b0;
      glitch_cnt_reg <= 32'h0000_0000;
    end else if (host_good_raw == host_good_filt_reg) begin
      glitch_cnt_reg <= 32'h0000_0000;
    end else if (glitch_cnt_reg == 32'(spus_pkg::DEGLITCH_CYCLES - 1)) begin
      host_good_filt_reg <= host_good_raw;
      glitch_cnt_reg <= 32'h0000_0000;
    end else begin
      glitch_cnt_reg <= glitch_cnt_reg + 32'h0000_0001;
    end
  end

  // supervision window restarts on enable rise or voltage change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup_run_reg <= 1'b0;
      sup_cnt_reg <= 32'h0000_0000;
      host_err_reg <= 1'b0;
    end else begin
      if (!host_en) begin
        sup_run_reg <= 1'b0; // regulator off: nothing to supervise
      end else if (!reg_ctl.host_supply_enable || vset_write) begin
        sup_run_reg <= 1'b1;
        sup_cnt_reg <= 32'h0000_0000;
      end else if (sup_run_reg) begin
        if (host_good_filt_reg) begin
          sup_run_reg <= 1'b0;
        end else if (sup_cnt_reg == 32'(spus_pkg::GOOD_TIMEOUT_CYCLES - 1)) begin
          sup_run_reg <= 1'b0;
        end else begin
          sup_cnt_reg <= sup_cnt_reg + 32'h0000_0001;
        end
      end
      // set wins over software clear
      if (irq_event[spus_pkg::IRQ_FAULT_BIT]) begin
        host_err_reg <= 1'b1;
      end else if (wr_fire && awaddr_reg == spus_pkg::IRQ_STATUS_OFS && wstrb_reg[0] &&
                   wdata_reg[spus_pkg::IRQ_FAULT_BIT]) begin
        host_err_reg <= 1'b0;
      end else if (state_reg == spus_pkg::ST_OFF) begin
        host_err_reg <= 1'b0;
      end
    end
  end

  // interrupt events, one-cycle pulses
  assign irq_event[spus_pkg::IRQ_FAULT_BIT] = sup_run_reg && host_en && !host_good_filt_reg && !vset_write &&
                                               reg_ctl.host_supply_enable &&
                                               sup_cnt_reg == 32'(spus_pkg::GOOD_TIMEOUT_CYCLES - 1);
  assign irq_event[spus_pkg::IRQ_ACTIVE_BIT] = (state_reg == spus_pkg::ST_ACTIVE) && !active_prev_reg;
  assign irq_event[spus_pkg::IRQ_SUPPLY_LOSS_BIT] = !supply_ok && (state_reg != spus_pkg::ST_OFF);
  assign irq_event[spus_pkg::IRQ_EXT_BIT] = ext_alert_s & !alert_prev_reg;

  // external alert pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_m_reg <= 1'b0;
      ext_alert_s <= 1'b0;
      alert_prev_reg <= 1'b0;
      active_prev_reg <= 1'b0;
    end else begin
      alert_m_reg <= ext_alert;
      ext_alert_s <= alert_m_reg;
      alert_prev_reg <= ext_alert_s;
      active_prev_reg <= (state_reg == spus_pkg::ST_ACTIVE);
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else if (wr_fire && awaddr_reg == spus_pkg::IRQ_STATUS_OFS && wstrb_reg[0]) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg[spus_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  // level interrupt from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // axi write: take address and data in either order, answer after both
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign vset_write = wr_fire && awaddr_reg == spus_pkg::CTRL_OFS && wstrb_reg[0] &&
                      wdata_reg[spus_pkg::CTRL_VSET_LSB +: 2] != vset_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spus_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg <= spus_pkg::IRQ_MASK_OFS && awaddr_reg[1:0] == 2'h0) ?
                       spus_pkg::RESP_OKAY : spus_pkg::RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and mask registers; strap end loads the supply code, over a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vset_reg <= spus_pkg::CTRL_RST[spus_pkg::CTRL_VSET_LSB +: 2];
      reg_off_reg <= spus_pkg::CTRL_RST[spus_pkg::CTRL_REG_OFF_BIT];
      fault_off_reg <= spus_pkg::CTRL_RST[spus_pkg::CTRL_FAULT_OFF_BIT];
      irq_mask_reg <= spus_pkg::IRQ_MASK_RST;
    end else begin
      if (state_reg == spus_pkg::ST_STRAP && timer_reg == 32'h0000_0000) begin
        vset_reg <= strap_pair[3:2];
      end else if (wr_fire && awaddr_reg == spus_pkg::CTRL_OFS && wstrb_reg[0]) begin
        vset_reg <= wdata_reg[spus_pkg::CTRL_VSET_LSB +: 2];
        reg_off_reg <= wdata_reg[spus_pkg::CTRL_REG_OFF_BIT];
        fault_off_reg <= wdata_reg[spus_pkg::CTRL_FAULT_OFF_BIT];
      end
      if (wr_fire && awaddr_reg == spus_pkg::IRQ_MASK_OFS && wstrb_reg[0]) begin
        irq_mask_reg <= wdata_reg[spus_pkg::IRQ_W-1:0];
      end
    end
  end

  // axi read: one cycle of arready, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= spus_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= spus_pkg::RESP_OKAY;
        case (s_axi_araddr[7:0])
          spus_pkg::CTRL_OFS: s_axi_rdata <= {26'h0, reg_ctl.boost_voltage, fault_off_reg, reg_off_reg, vset_reg};
          spus_pkg::STATUS_OFS: s_axi_rdata <= {26'h0, host_err_reg, host_good_filt_reg, 1'b0, state_reg};
          spus_pkg::IRQ_STATUS_OFS: s_axi_rdata <= {28'h0, irq_stat_reg};
          spus_pkg::IRQ_MASK_OFS: s_axi_rdata <= {28'h0, irq_mask_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spus_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // spus_sequencer

// ### spus_pkg.sv
// package for the supply power-up sequencer: offsets, fields, codes, timing
package spus_pkg;
  // clock rate
  localparam int CLK_MHZ = 100;
  // timing figures in their own units
  localparam int INIT_TIME_MS = 6;
  localparam int STRAP_TIME_MS = 2;
  localparam int DEGLITCH_TIME_US = 125;
  localparam int GOOD_TIMEOUT_MS = 10;
  // derived cycle counts
  localparam int INIT_CYCLES = INIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int STRAP_CYCLES = STRAP_TIME_MS * 1000 * CLK_MHZ;
  localparam int DEGLITCH_CYCLES = DEGLITCH_TIME_US * CLK_MHZ;
  localparam int GOOD_TIMEOUT_CYCLES = GOOD_TIMEOUT_MS * 1000 * CLK_MHZ;
  // wait after a boost code change before trusting boost good again;
  // covers the two sync flops, a slower comparator needs more
  localparam int BOOST_SETTLE_CYCLES = 4;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // control fields
  localparam int CTRL_VSET_LSB = 0;
  localparam int CTRL_REG_OFF_BIT = 2;
  localparam int CTRL_FAULT_OFF_BIT = 3;
  localparam int CTRL_BOOST_LSB = 4;
  // interrupt event bits
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_ACTIVE_BIT = 1;
  localparam int IRQ_SUPPLY_LOSS_BIT = 2;
  localparam int IRQ_EXT_BIT = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // host supply voltage codes
  localparam logic [1:0] VSET_1V5 = 2'h0;
  localparam logic [1:0] VSET_1V8 = 2'h1;
  localparam logic [1:0] VSET_2V5 = 2'h2;
  localparam logic [1:0] VSET_3V3 = 2'h3;
  // boost voltage codes
  localparam logic [1:0] BOOST_2V7 = 2'h0;
  localparam logic [1:0] BOOST_3V8 = 2'h1;
  localparam logic [1:0] BOOST_4V7 = 2'h2;
  // strap readings from the analog strap sensor
  localparam logic [1:0] STRAP_RES_GND = 2'h0;
  localparam logic [1:0] STRAP_SHORT_GND = 2'h1;
  localparam logic [1:0] STRAP_SHORT_CORE = 2'h2;
  localparam logic [1:0] STRAP_CAP_GND = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_INIT, ST_BOOST_WAIT, ST_STRAP, ST_BOOST_RESET_WAIT, ST_HOST_WAIT, ST_ACTIVE, ST_FAULT
  } spus_state_t;
  // analog power-good inputs grouped
  typedef struct packed {
    logic supply_above_detect;
    logic boost_good;
    logic host_supply_good;
  } spus_analog_t;
  // regulator controls grouped
  typedef struct packed {
    logic boost_enable;
    logic [1:0] boost_voltage;
    logic host_supply_enable;
    logic [1:0] host_supply_voltage_setting;
    logic core_supply_enable;
  } spus_reg_ctl_t;
endpackage

// ### spus_sequencer_sva.sv
// checker for the supply power-up sequencer ports
`timescale 1ns/1ps
module spus_sequencer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spus_pkg::spus_analog_t analog_in,
  input wire spus_pkg::spus_reg_ctl_t reg_ctl
);
  localparam int INIT_CYC = spus_pkg::INIT_CYCLES; // init hold length
  localparam int STRAP_CYC = spus_pkg::STRAP_CYCLES; // strap sense length
  int init_cnt; // cycles since raw supply detect
  int en_cnt; // cycles since boost enable
  // saturating counter of raw supply-up time; raw, so sync lag shows as slack
  always_ff @(posedge aclk) begin
    if (!aresetn || !analog_in.supply_above_detect) init_cnt <= 0;
    else if (init_cnt < INIT_CYC + 100) init_cnt <= init_cnt + 1;
  end
  // saturating counter of boost-on time
  always_ff @(posedge aclk) begin
    if (!aresetn || !reg_ctl.boost_enable) en_cnt <= 0;
    else if (en_cnt < STRAP_CYC + 100) en_cnt <= en_cnt + 1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_core_always_on: assert property ($past(aresetn) |-> reg_ctl.core_supply_enable)
    else $error("core regulator off");
  a_init_hold_time: assert property ($rose(reg_ctl.boost_enable) |-> init_cnt >= INIT_CYC && init_cnt <= INIT_CYC + 8)
    else $error("boost enabled off init time");
  a_boost_first_code: assert property ($rose(reg_ctl.boost_enable) |-> reg_ctl.boost_voltage == spus_pkg::BOOST_3V8)
    else $error("boost not started at 3.8 code");
  a_strap_sense_time: assert property (reg_ctl.boost_enable && $past(reg_ctl.boost_enable) && en_cnt < STRAP_CYC
    |-> $stable(reg_ctl.boost_voltage))
    else $error("boost code changed before strap end");
  a_host_after_boost: assert property ($rose(reg_ctl.host_supply_enable) |-> $past(analog_in.boost_good, 3))
    else $error("host regulator on without boost good");
  a_loss_turns_off: assert property (!analog_in.supply_above_detect [*6]
    |-> !reg_ctl.boost_enable && !reg_ctl.host_supply_enable)
    else $error("regulators on after supply loss");
  a_write_answer: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2) && $past(s_axi_wready, 2))
    else $error("write response timing");
  a_read_answer: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not dropped");
endmodule // spus_sequencer_sva
bind spus_sequencer spus_sequencer_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_in(analog_in), .reg_ctl(reg_ctl));

// ### spus_analog_model.sv
// analog side model: supply detect, boost and host supply power-good
`timescale 1ns/1ps
module spus_analog_model (
  input wire logic aclk,
  input wire logic supply_on,
  input wire logic glitch,
  input wire spus_pkg::spus_reg_ctl_t reg_ctl,
  output spus_pkg::spus_analog_t analog_in
);
  int boost_cnt = 0; // cycles boost settled at its code
  int host_cnt = 0; // cycles host regulator on
  logic [1:0] boost_last = 2'h0; // boost code one cycle ago
  // boost ramps 50 cycles after enable or a code change, good near target
  always_ff @(posedge aclk) begin
    boost_last <= reg_ctl.boost_voltage;
    if (!supply_on || !reg_ctl.boost_enable || reg_ctl.boost_voltage != boost_last) boost_cnt <= 0;
    else if (boost_cnt < 50) boost_cnt <= boost_cnt + 1;
  end
  // host rail ramps 100 cycles after enable, drops at once when off
  always_ff @(posedge aclk) begin
    if (!supply_on || !reg_ctl.host_supply_enable) host_cnt <= 0;
    else if (host_cnt < 100) host_cnt <= host_cnt + 1;
  end
  // glitch pulls good low while high; the filter must hide short dips
  assign analog_in = {supply_on, boost_cnt >= 50, host_cnt >= 100 && !glitch};
endmodule // spus_analog_model

// ### tb_top.sv
// testbench for the supply power-up sequencer
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0; // clock and reset
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0; // bus payloads
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] strap = 2'h0; // strap sensor reading
  logic ext_alert = 1'b0, supply_on = 1'b0, glitch = 1'b0;
  spus_pkg::spus_analog_t analog_in;
  spus_pkg::spus_reg_ctl_t reg_ctl;
  int miscompares = 0, n_tests = 0;
  logic [31:0] rd; // last read data
  logic [1:0] rs; // last response
  spus_sequencer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .analog_in(analog_in),
    .supply_select_strap(strap), .ext_alert(ext_alert), .reg_ctl(reg_ctl), .irq(irq));
  spus_analog_model u_model (.aclk(aclk), .supply_on(supply_on), .glitch(glitch), .reg_ctl(reg_ctl),
    .analog_in(analog_in));
  // free-running 100 mhz clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a bound ran out: count it and stop
  task automatic fail_wait();
    miscompares++;
    $display("unexpected %0t wait limit", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one write; aw and w offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (i == 50) fail_wait();
  endtask
  // one read; data taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (i == 50) fail_wait();
  endtask
  // poll the state field, bounded by a read count
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      axi_rd(spus_pkg::STATUS_OFS);
      if (rd[2:0] === s) return;
    end
    fail_wait();
  endtask
  task automatic t_reset();
    repeat (2) @(posedge aclk);
    chk(32'(reg_ctl.core_supply_enable), 32'h1, "core on");
    axi_rd(spus_pkg::CTRL_OFS);
    chk({rd[31:6], 2'h0, rd[3:0]}, {spus_pkg::CTRL_RST[31:6], 2'h0, spus_pkg::CTRL_RST[3:0]}, "ctrl reset");
    chk(32'(rd[5:4]), 32'(spus_pkg::BOOST_3V8), "boost code before init");
    axi_rd(spus_pkg::IRQ_MASK_OFS);
    chk(32'(rd[3:0]), 32'(spus_pkg::IRQ_MASK_RST), "mask reset");
    axi_rd(spus_pkg::STATUS_OFS);
    chk(32'(rd[2:0]), 32'(spus_pkg::ST_OFF), "state off");
  endtask
  // full power-up with the capacitor strap: 3.3 v host, 4.7 v boost
  task automatic t_powerup();
    strap <= spus_pkg::STRAP_CAP_GND;
    supply_on <= 1'b1;
    repeat (590000) @(posedge aclk);
    chk(32'(reg_ctl.boost_enable), 32'h0, "boost during init");
    wait_state(spus_pkg::ST_STRAP, 10000);
    chk(32'({reg_ctl.boost_enable, reg_ctl.boost_voltage}), 32'({1'b1, spus_pkg::BOOST_3V8}), "boost start");
    wait_state(spus_pkg::ST_HOST_WAIT, 60000);
    chk(32'(reg_ctl.boost_voltage), 32'(spus_pkg::BOOST_4V7), "strap boost");
    chk(32'(reg_ctl.host_supply_voltage_setting), 32'(spus_pkg::VSET_3V3), "strap vset");
    chk(32'(reg_ctl.host_supply_enable), 32'h1, "host on");
    wait_state(spus_pkg::ST_ACTIVE, 5000);
    chk(32'(rd[4]), 32'h1, "filtered good");
    axi_rd(spus_pkg::IRQ_STATUS_OFS);
    chk(32'(rd[spus_pkg::IRQ_ACTIVE_BIT]), 32'h1, "active event");
  endtask
  // mask gates irq, w1c clears, ext alert edge latches
  task automatic t_irq();
    chk(32'(irq), 32'h0, "irq masked");
    axi_wr(spus_pkg::IRQ_MASK_OFS, 32'h1 << spus_pkg::IRQ_ACTIVE_BIT);
    chk(32'(rs), 32'(spus_pkg::RESP_OKAY), "write okay");
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1, "irq raised");
    axi_wr(spus_pkg::IRQ_STATUS_OFS, 32'h1 << spus_pkg::IRQ_ACTIVE_BIT);
    ext_alert <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq cleared");
    axi_rd(spus_pkg::IRQ_STATUS_OFS);
    chk(32'(rd[3:0]), 32'h8, "alert latched");
    ext_alert <= 1'b0;
    axi_wr(spus_pkg::IRQ_STATUS_OFS, 32'hf);
    axi_wr(spus_pkg::IRQ_MASK_OFS, 32'hf);
  endtask
  // short dip on host good must not reach the filtered flag
  task automatic t_glitch();
    glitch <= 1'b1;
    repeat (1000) @(posedge aclk);
    glitch <= 1'b0;
    axi_rd(spus_pkg::STATUS_OFS);
    chk(32'(rd[4:0]), 32'h16, "glitch hidden");
    glitch <= 1'b1;
    repeat (spus_pkg::DEGLITCH_CYCLES + 100) @(posedge aclk);
    axi_rd(spus_pkg::STATUS_OFS);
    chk(32'(rd[4]), 32'h0, "long dip passes");
    glitch <= 1'b0;
    repeat (spus_pkg::DEGLITCH_CYCLES + 100) @(posedge aclk);
    axi_rd(spus_pkg::STATUS_OFS);
    chk(32'(rd[4]), 32'h1, "good restored");
  endtask
  // live code changes and regulator off, no restart
  task automatic t_vset();
    for (int c = 0; c < 4; c++) begin
      axi_wr(spus_pkg::CTRL_OFS, 32'(c));
      repeat (3) @(posedge aclk);
      chk(32'(reg_ctl.host_supply_voltage_setting), 32'(c), "sw vset");
      axi_rd(spus_pkg::STATUS_OFS);
      chk(32'(rd[2:0]), 32'(spus_pkg::ST_ACTIVE), "no restart");
    end
    axi_rd(spus_pkg::CTRL_OFS);
    chk(32'(rd[5:4]), 32'(spus_pkg::BOOST_4V7), "boost field ro");
    axi_wr(spus_pkg::CTRL_OFS, 32'h1 << spus_pkg::CTRL_REG_OFF_BIT);
    repeat (3) @(posedge aclk);
    chk(32'(reg_ctl.host_supply_enable), 32'h0, "regulator off");
  endtask
  task automatic t_bad_addr();
    axi_rd(8'h10);
    chk(32'(rs), 32'(spus_pkg::RESP_SLVERR), "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    axi_wr(8'h20, 32'hffffffff);
    chk(32'(rs), 32'(spus_pkg::RESP_SLVERR), "unmapped write");
  endtask
  // supply loss drops boost (host already off), raises irq and flags the event
  task automatic t_loss();
    supply_on <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'({reg_ctl.boost_enable, reg_ctl.host_supply_enable, irq}), 32'h1, "loss off");
    axi_rd(spus_pkg::STATUS_OFS);
    chk(32'(rd[2:0]), 32'(spus_pkg::ST_OFF), "back off");
    axi_rd(spus_pkg::IRQ_STATUS_OFS);
    chk(32'(rd[spus_pkg::IRQ_SUPPLY_LOSS_BIT]), 32'h1, "loss event");
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_powerup();
    t_irq();
    t_glitch();
    t_vset();
    t_bad_addr();
    t_loss();
    tally_and_finish();
  end
endmodule // tb_top
